// ===== src/tsc_timer.sv
// timer status and control block with avalon-mm slave
`timescale 1ns/1ps
module tsc_timer (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic capture_in,
    output logic irq
);
    import tsc_pkg::*;

    tsc_cnt_if cnt ();

    // ************************************************************************
    // bus handshake
    // ************************************************************************
    tsc_bus_state_t state_q;
    logic access;
    logic rd_done;
    logic wr_done;

    // one wait cycle, then the access completes
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= TSC_IDLE;
        end else begin
            unique case (state_q)
                TSC_IDLE: begin
                    if (avs_read || avs_write) begin
                        state_q <= TSC_ANSWER;
                    end
                end
                TSC_ANSWER: begin
                    state_q <= TSC_IDLE;
                end
            endcase
        end
    end

    assign access = (state_q == TSC_ANSWER);
    assign avs_waitrequest = (avs_read || avs_write) && !access;
    assign rd_done = access && avs_read;
    assign wr_done = access && avs_write && avs_byteenable[0];

    // ************************************************************************
    // control registers
    // ************************************************************************
    logic irq_en_q;
    logic halt_q;
    logic [2:0] prescale_q;
    logic clear_q;
    logic [15:0] modulo_q;
    logic ctrl_wr;
    logic hi_wr;

    assign ctrl_wr = wr_done && (avs_address == ADDR_STATUS_CONTROL);
    assign hi_wr = access && avs_write && avs_byteenable[1];

    // enable, halt and prescale fields
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            irq_en_q <= RST_STATUS_CONTROL[BIT_OVERFLOW_IRQ_ENABLE];
            halt_q <= RST_STATUS_CONTROL[BIT_COUNTER_HALT];
            prescale_q <= RST_STATUS_CONTROL[BIT_PRESCALE_LO +: PRESCALE_WIDTH];
        end else if (ctrl_wr) begin
            irq_en_q <= avs_writedata[BIT_OVERFLOW_IRQ_ENABLE];
            halt_q <= avs_writedata[BIT_COUNTER_HALT];
            prescale_q <= avs_writedata[BIT_PRESCALE_LO +: PRESCALE_WIDTH];
        end
    end

    // self-clearing counter clear pulse, also zeroes the prescaler and masks the overflow pulse
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            clear_q <= RST_STATUS_CONTROL[BIT_COUNTER_CLEAR];
        end else begin
            clear_q <= ctrl_wr && avs_writedata[BIT_COUNTER_CLEAR];
        end
    end

    // modulo value
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            modulo_q <= RST_MODULO;
        end else if (access && avs_write && (avs_address == ADDR_MODULO)) begin
            if (avs_byteenable[0]) begin
                modulo_q[7:0] <= avs_writedata[7:0];
            end
            if (hi_wr) begin
                modulo_q[15:8] <= avs_writedata[15:8];
            end
        end
    end

    assign cnt.halt = halt_q;
    assign cnt.clear = clear_q;
    assign cnt.prescale = prescale_q;
    assign cnt.modulo = modulo_q;

    tsc_counter u_counter (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .cnt(cnt)
    );

    // ************************************************************************
    // overflow flag with guarded clear
    // ************************************************************************
    logic flag_q;
    logic armed_q;
    logic flag_rd;
    logic clear_req;

    assign flag_rd = rd_done && (avs_address == ADDR_STATUS_CONTROL) && flag_q;
    assign clear_req = ctrl_wr && !avs_writedata[BIT_OVERFLOW_FLAG] && armed_q;

    // arm on a read that sees the flag set; a fresh overflow disarms
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            armed_q <= 1'b0;
        end else if (cnt.overflow) begin
            armed_q <= 1'b0;
        end else if (flag_rd) begin
            armed_q <= 1'b1;
        end else if (ctrl_wr) begin
            armed_q <= 1'b0;
        end
    end

    // set wins over clear
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            flag_q <= 1'b0;
        end else if (cnt.overflow) begin
            flag_q <= 1'b1;
        end else if (clear_req) begin
            flag_q <= 1'b0;
        end
    end

    // level interrupt while flag and enable are set
    assign irq = flag_q && irq_en_q;

    // ************************************************************************
    // input capture
    // ************************************************************************
    logic cap_s1_q;
    logic cap_s2_q;
    logic cap_s3_q;
    logic [15:0] capture_q;

    // two-flop synchroniser plus edge history
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cap_s1_q <= 1'b0;
            cap_s2_q <= 1'b0;
            cap_s3_q <= 1'b0;
        end else begin
            cap_s1_q <= capture_in;
            cap_s2_q <= cap_s1_q;
            cap_s3_q <= cap_s2_q;
        end
    end

    // latch count on a rising edge unless halted
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            capture_q <= RST_COUNTER;
        end else if (cap_s2_q && !cap_s3_q && !halt_q) begin
            capture_q <= cnt.count;
        end
    end

    // ************************************************************************
    // read data
    // ************************************************************************
    logic [31:0] rdata_d;

    // clear bit always reads as zero
    always_comb begin
        rdata_d = 32'h0000_0000;
        unique case (avs_address)
            ADDR_STATUS_CONTROL: begin
                rdata_d[BIT_OVERFLOW_FLAG] = flag_q;
                rdata_d[BIT_OVERFLOW_IRQ_ENABLE] = irq_en_q;
                rdata_d[BIT_COUNTER_HALT] = halt_q;
                rdata_d[BIT_COUNTER_CLEAR] = 1'b0;
                rdata_d[BIT_PRESCALE_LO +: PRESCALE_WIDTH] = prescale_q;
            end
            ADDR_MODULO: rdata_d[15:0] = modulo_q;
            ADDR_COUNTER: rdata_d[15:0] = cnt.count;
            ADDR_CAPTURE: rdata_d[15:0] = capture_q;
            default: rdata_d = 32'h0000_0000;
        endcase
    end

    // read data register captured while waitrequest is high
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read && !access) begin
            avs_readdata <= rdata_d;
        end
    end
endmodule

// ===== shared/tsc_pkg.sv
// package of constants and types for the timer status and control block
// ****************************************************************************
// ****************************************************************************
package tsc_pkg;
    // register word offsets (byte addresses)
    localparam logic [3:0] ADDR_STATUS_CONTROL = 4'h0;
    localparam logic [3:0] ADDR_MODULO = 4'h4;
    localparam logic [3:0] ADDR_COUNTER = 4'h8;
    localparam logic [3:0] ADDR_CAPTURE = 4'hc;
    localparam logic [3:0] ADDR_IRQ_STATUS = 4'h0 + 4'h0 + 4'h0 + 4'h0;
    // status/control field positions
    localparam int BIT_OVERFLOW_FLAG = 7;
    localparam int BIT_OVERFLOW_IRQ_ENABLE = 6;
    localparam int BIT_COUNTER_HALT = 5;
    localparam int BIT_COUNTER_CLEAR = 4;
    localparam int BIT_PRESCALE_LO = 0;
    localparam int PRESCALE_WIDTH = 3;
    // reset values
    localparam logic [7:0] RST_STATUS_CONTROL = 8'h20;
    localparam logic [15:0] RST_MODULO = 16'hffff;
    localparam logic [15:0] RST_COUNTER = 16'h0000;
    localparam logic [6:0] RST_PRESCALER = 7'h00;
    // bus answer timing: one wait cycle per access
    localparam int BUS_WAIT_CYCLES = 1;
    typedef enum logic [1:0] {
        TSC_IDLE,
        TSC_ANSWER
    } tsc_bus_state_t;
endpackage

// ===== shared/tsc_cnt_if.sv
// interface between the register slave and the counter core
`timescale 1ns/1ps
interface tsc_cnt_if;
    logic halt;
    logic clear;
    logic [2:0] prescale;
    logic [15:0] modulo;
    logic [15:0] count;
    logic overflow;
    modport ctrl (output halt, output clear, output prescale, output modulo, input count, input overflow);
    modport core (input halt, input clear, input prescale, input modulo, output count, output overflow);
endinterface

// ===== src/tsc_counter.sv
// prescaler and 16-bit modulo counter core
`timescale 1ns/1ps
module tsc_counter (
    input wire logic sys_clk,
    input wire logic rstn,
    tsc_cnt_if.core cnt
);
    import tsc_pkg::*;

    logic [6:0] presc_q;
    logic [15:0] count_q;
    logic tick;
    logic at_mod;

    // prescaled tick: divide by 2^prescale
    always_comb begin
        tick = ((presc_q & ((7'h01 << cnt.prescale) - 7'h01)) == 7'h00);
    end

    assign at_mod = (count_q == cnt.modulo);

    // prescaler runs while not halted, clear zeroes it
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            presc_q <= RST_PRESCALER;
        end else if (cnt.clear) begin
            presc_q <= RST_PRESCALER;
        end else if (!cnt.halt) begin
            presc_q <= presc_q + 7'h01;
        end
    end

    // counter with modulo wrap
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            count_q <= RST_COUNTER;
        end else if (cnt.clear) begin
            count_q <= RST_COUNTER;
        end else if (!cnt.halt && tick) begin
            if (at_mod) begin
                count_q <= RST_COUNTER;
            end else begin
                count_q <= count_q + 16'h0001;
            end
        end
    end

    // one-cycle pulse when the counter first reaches the modulo value
    logic at_mod_q;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            at_mod_q <= 1'b0;
        end else begin
            at_mod_q <= at_mod;
        end
    end

    assign cnt.count = count_q;
    assign cnt.overflow = at_mod && !at_mod_q && !cnt.clear;
endmodule

// ===== tb/tsc_timer_props.sv
// checker of bus timing and interrupt behaviour at the timer ports
`timescale 1ns/1ps
module tsc_timer_props
    import tsc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic capture_in,
    input wire logic irq
);
    // ****************************************
    // helpers and properties
    // ****************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    // completed control write through lane 0
    logic ctl_wr;
    assign ctl_wr = avs_write && !avs_waitrequest && avs_address == ADDR_STATUS_CONTROL && avs_byteenable[0];
    sequence one_wait;
        avs_waitrequest ##1 !avs_waitrequest;
    endsequence
    sequence rd_done;
        avs_read && !avs_waitrequest;
    endsequence
    read_wait_a: assert property ($rose(avs_read) |-> one_wait)
        else $error("read answer timing wrong");
    write_wait_a: assert property ($rose(avs_write) |-> one_wait)
        else $error("write answer timing wrong");
    unmapped_zero_a: assert property (rd_done |-> avs_address[1:0] != 2'b00 |-> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    clear_reads_zero_a: assert property (rd_done |-> avs_address != ADDR_STATUS_CONTROL || !avs_readdata[4])
        else $error("clear bit read as one");
    reset_irq_low_a: assert property ($rose(rstn) |-> !irq)
        else $error("irq high after reset");
    mask_irq_low_a: assert property (ctl_wr && !avs_writedata[6] |=> !irq)
        else $error("irq high with enable off");
    write_one_keeps_a: assert property (irq && ctl_wr && avs_writedata[7:6] == 2'b11 |=> irq)
        else $error("write of one cleared flag");
    readdata_stands_a: assert property ($changed(avs_readdata) |-> $past(avs_read && avs_waitrequest))
        else $error("read data changed without read");
endmodule

// ===== tb/tsc_timer_tb.sv
// self-checking testbench of the timer status and control block
`timescale 1ns/1ps
module tsc_timer_tb;
    import tsc_pkg::*;
    logic sys_clk = 0, rstn = 0, avs_read = 0, avs_write = 0, capture_in = 0;
    logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hf;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rd, cap, lf = 32'hbefdd1de;
    logic avs_waitrequest, irq;
    int fails = 0, n_compared = 0, flag = 0, ie = 0, halt = 1, modv = 0;
    // ****************************************
    // clock, design and tasks
    // ****************************************
    always #12.5 sys_clk = ~sys_clk;
    tsc_timer dut (.sys_clk(sys_clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .capture_in(capture_in), .irq(irq));
    function automatic logic [31:0] lfsr(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // one avalon access, held until waitrequest is seen low
    task automatic bus(input bit wr, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        @(posedge sys_clk);
        #1;
        while (avs_waitrequest !== 1'b0 && n < 50) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        @(posedge sys_clk);
        rd = avs_readdata;
        if (n >= 50) fails++;
        avs_write <= 0;
        avs_read <= 0;
        @(posedge sys_clk);
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            $display("mismatch %s expected %h seen %h", nm, e, g);
            fails++;
        end
    endtask
    // read control byte and compare with the model
    task automatic rdctl();
        bus(0, ADDR_STATUS_CONTROL, 0);
        chk("ctrl", {24'h0, flag[0], ie[0], halt[0], 5'h0}, rd & 32'hf7);
    endtask
    task automatic wait_irq();
        int n;
        for (n = 0; n < 300 && irq !== 1'b1; n++) @(posedge sys_clk);
    endtask
    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge sys_clk);
        fails++;
        tally_and_finish();
    end
    // ****************************************
    // scenarios
    // ****************************************
    initial begin
        repeat (20) @(posedge sys_clk);
        rstn <= 1;
        @(posedge sys_clk);
        rdctl();
        bus(0, ADDR_MODULO, 0);
        chk("modulo", 32'hffff, rd);
        bus(0, ADDR_COUNTER, 0);
        chk("counter", 32'h0, rd);
        bus(0, ADDR_CAPTURE, 0);
        cap = rd;
        capture_in <= 1;
        repeat (4) @(posedge sys_clk);
        capture_in <= 0;
        repeat (4) @(posedge sys_clk);
        bus(0, ADDR_CAPTURE, 0);
        chk("capture", cap, rd);
        bus(1, 4'h1, 32'hffffffff);
        bus(0, 4'h2, 0);
        chk("unmapped", 32'h0, rd);
        $display("test reset done");
        lf = lfsr(lf);
        modv = 16 + lf[3:0];
        bus(1, ADDR_MODULO, modv);
        ie = 1;
        halt = 0;
        bus(1, ADDR_STATUS_CONTROL, 32'h40);
        wait_irq();
        flag = 1;
        chk("irq", 1, irq);
        rdctl();
        bus(1, ADDR_STATUS_CONTROL, 32'hc0);
        chk("irq", 1, irq);
        halt = 1;
        bus(1, ADDR_STATUS_CONTROL, 32'h60);
        rdctl();
        bus(0, ADDR_COUNTER, 0);
        cap = rd;
        bus(0, ADDR_COUNTER, 0);
        chk("held", cap, rd);
        flag = 0;
        bus(1, ADDR_STATUS_CONTROL, 32'h60);
        chk("irq", 0, irq);
        rdctl();
        $display("test clear sequence done");
        halt = 0;
        bus(1, ADDR_STATUS_CONTROL, 32'h40);
        wait_irq();
        flag = 1;
        rdctl();
        repeat (2 * modv + 4) @(posedge sys_clk);
        bus(1, ADDR_STATUS_CONTROL, 32'h40);
        rdctl();
        ie = 0;
        bus(1, ADDR_STATUS_CONTROL, 32'h80);
        chk("irq", 0, irq);
        ie = 1;
        halt = 1;
        bus(1, ADDR_STATUS_CONTROL, 32'hf0);
        bus(0, ADDR_COUNTER, 0);
        chk("counter", 32'h0, rd);
        rdctl();
        bus(0, ADDR_MODULO, 0);
        chk("modulo", modv, rd);
        $display("test overflow and clear done");
        rstn <= 0;
        repeat (2) @(posedge sys_clk);
        rstn <= 1;
        @(posedge sys_clk);
        flag = 0;
        ie = 0;
        halt = 1;
        rdctl();
        chk("irq", 0, irq);
        $display("test mid-run reset done");
        tally_and_finish();
    end
endmodule
bind tsc_timer tsc_timer_props u_props (.sys_clk(sys_clk), .rstn(rstn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .capture_in(capture_in), .irq(irq));
